// *** verilog/stc_pkg.sv ***
// Constants for the system clock tree control block
package stc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_OSC = 8'h00;
    localparam logic [7:0] OFS_LOOP = 8'h04;
    localparam logic [7:0] OFS_RUN = 8'h08;
    localparam logic [7:0] OFS_VLP = 8'h0c;
    localparam logic [7:0] OFS_PERI = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OSC_EN_BIT = 0;
    localparam int OSC_RANGE_LSB = 1;
    localparam int OSC_REFSEL_BIT = 3;
    localparam int FAST_EN_BIT = 4;
    localparam int SLOW_EN_BIT = 5;
    localparam int LOOP_EN_BIT = 0;
    localparam int LOOP_PREDIV_LSB = 1;
    localparam int LOOP_MULT_LSB = 4;
    localparam int BUSDIV_LSB = 0;
    localparam int COREDIV_LSB = 16;
    localparam int SYSSRC_LSB = 24;
    localparam int PSEL_LSB = 16;
    localparam int PBUS_EN_BIT = 20;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] OSC_RST = 32'h0000_0030;
    localparam logic [31:0] LOOP_RST = 32'h0000_0000;
    localparam logic [31:0] CFG_RST = 32'h0200_0000;
    localparam logic [31:0] PERI_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] RANGE_HIGH = 2'h3;
    localparam logic [5:0] LOOP_MULT_BASE = 6'h10;
    localparam logic [8:0] CREDIT_MAX = 9'h0ff;

    typedef enum logic [3:0] {
        SRC_NONE = 4'h0,
        SRC_CRYSTAL = 4'h1,
        SRC_SLOW = 4'h2,
        SRC_FAST = 4'h3,
        SRC_LOOP = 4'h6
    } stc_src_t;

endpackage

// *** verilog/stc_tick_div.sv ***
// Tick divider by field value plus one, held while its source is off
`timescale 1ns/1ps
module stc_tick_div (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Source
    input wire logic src_on_i,
    input wire logic tick_i,
    input wire logic [3:0] ratio_i,
    // Divided tick
    output logic tick_o
);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic next_tick;

    always_comb begin
        next_cnt = cnt;
        next_tick = 1'b0;
        if (!src_on_i) begin
            next_cnt = 4'h0; // R18
        end else if (tick_i) begin
            if (cnt >= ratio_i) begin
                next_cnt = 4'h0; // R17
                next_tick = 1'b1;
            end else begin
                next_cnt = cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 4'h0;
            tick_o <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_o <= next_tick;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_div_cause: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        tick_o |-> $past(tick_i) && $past(src_on_i))
        else $error("divided tick without source tick");
    a_div_unity: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        src_on_i && tick_i && ratio_i == 4'h0 |=> tick_o)
        else $error("ratio zero did not pass tick");
    a_div_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        !src_on_i |=> !tick_o)
        else $error("tick while source off");

endmodule

// *** verilog/stc_clock_tree.sv ***
// System clock tree control: oscillators, loop, dividers, peripheral clock
//
// Functional notes
// R1: Oscillator range value 3 selects the high 8-40 MHz crystal range.
// R2: Oscillator clock reaches consumers only while its enable is 1.
// R3: Reference select 1 takes the crystal, 0 the external clock pin.
// R4: Loop reference is only the oscillator clock, never an RC source.
// R5: Loop runs and ticks only while its enable is 1.
// R6: Prediv 0, multiplier 8 on 8 MHz reference gives 96 MHz.
// R7: Software keeps loop at most 160 MHz, its oscillator 320 MHz.
// R8: System source value 6 routes the loop output to system clocks.
// R9: System source value 2 routes the slow RC clock.
// R10: Core divider field 1 divides by two for core and system clock.
// R11: Bus divider is fed by the core divider output.
// R12: Selector and divider set follows the current power mode.
// R13: Software keeps core and system clock at most 48 MHz in run.
// R14: Only fast RC, slow RC, crystal and low power osc are roots; the code also takes external_clock_pin_i as a root, used at reference select 0.
// R15: Peripheral bus clock is bus clock; function clock from four sources.
// R16: Peripheral select 0 keeps the function clock stopped.
// R17: Divider fields 0 to 15 divide by field plus one.
// R18: A clock with a disabled source holds still until re-enabled.
`timescale 1ns/1ps
module stc_clock_tree (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Root sources
    input wire logic crystal_input_i,
    input wire logic external_clock_pin_i,
    input wire logic fast_rc_tick_i,
    input wire logic slow_rc_tick_i,
    input wire logic low_power_osc_tick_i,
    // Power mode
    input wire logic lp_mode_i,
    // Clock enables and high range flag out
    output logic crystal_osc_clock_o,
    output logic loop_clock_o,
    output logic platform_clock_o,
    output logic bus_clock_o,
    output logic periph_bus_clock_o,
    output logic periph_func_clock_o,
    output logic low_power_osc_clock_o,
    output logic high_range_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic pick_src(input logic [3:0] code,
        input logic x, input logic s, input logic f, input logic l);
        logic r;
        r = 1'b0;
        case (code)
            stc_pkg::SRC_CRYSTAL: r = x;
            stc_pkg::SRC_SLOW: r = s; // R9
            stc_pkg::SRC_FAST: r = f;
            stc_pkg::SRC_LOOP: r = l; // R8
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old,
        input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0] osc_reg, loop_reg, run_reg, vlp_reg, peri_reg;
    logic [31:0] next_osc_reg, next_loop_reg, next_run_reg;
    logic [31:0] next_vlp_reg, next_peri_reg;
    logic served, next_served;
    logic [31:0] next_rdata;
    logic [31:0] stat_word;
    logic req;

    assign req = avs_read_i | avs_write_i;
    // One wait cycle: request taken on the edge where served is cleared
    assign avs_waitrequest_o = req & ~served;

    always_comb begin
        next_osc_reg = osc_reg;
        next_loop_reg = loop_reg;
        next_run_reg = run_reg;
        next_vlp_reg = vlp_reg;
        next_peri_reg = peri_reg;
        next_served = req & ~served;
        next_rdata = avs_readdata_o;
        if (avs_write_i && served) begin
            unique case (avs_address_i)
                stc_pkg::OFS_OSC: next_osc_reg =
                    merge_be(osc_reg, avs_writedata_i, avs_byteenable_i);
                stc_pkg::OFS_LOOP: next_loop_reg =
                    merge_be(loop_reg, avs_writedata_i, avs_byteenable_i);
                stc_pkg::OFS_RUN: next_run_reg =
                    merge_be(run_reg, avs_writedata_i, avs_byteenable_i);
                stc_pkg::OFS_VLP: next_vlp_reg =
                    merge_be(vlp_reg, avs_writedata_i, avs_byteenable_i);
                stc_pkg::OFS_PERI: next_peri_reg =
                    merge_be(peri_reg, avs_writedata_i, avs_byteenable_i);
                default: ;
            endcase
        end
        if (avs_read_i && !served) begin
            unique case (avs_address_i)
                stc_pkg::OFS_OSC: next_rdata = osc_reg;
                stc_pkg::OFS_LOOP: next_rdata = loop_reg;
                stc_pkg::OFS_RUN: next_rdata = run_reg;
                stc_pkg::OFS_VLP: next_rdata = vlp_reg;
                stc_pkg::OFS_PERI: next_rdata = peri_reg;
                stc_pkg::OFS_STAT: next_rdata = stat_word;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osc_reg <= stc_pkg::OSC_RST;
            loop_reg <= stc_pkg::LOOP_RST;
            run_reg <= stc_pkg::CFG_RST;
            vlp_reg <= stc_pkg::CFG_RST;
            peri_reg <= stc_pkg::PERI_RST;
            served <= 1'b0;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            osc_reg <= next_osc_reg;
            loop_reg <= next_loop_reg;
            run_reg <= next_run_reg;
            vlp_reg <= next_vlp_reg;
            peri_reg <= next_peri_reg;
            served <= next_served;
            avs_readdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic osc_en, ref_sel, fast_en, slow_en, loop_en, loop_run;
    logic [1:0] osc_range;
    logic [2:0] prediv;
    logic [4:0] mult;
    logic [31:0] act_cfg;
    logic [3:0] act_src, act_core, act_bus;
    logic [2:0] psel;

    assign osc_en = osc_reg[stc_pkg::OSC_EN_BIT];
    assign osc_range = osc_reg[stc_pkg::OSC_RANGE_LSB +: 2];
    assign ref_sel = osc_reg[stc_pkg::OSC_REFSEL_BIT];
    assign fast_en = osc_reg[stc_pkg::FAST_EN_BIT];
    assign slow_en = osc_reg[stc_pkg::SLOW_EN_BIT];
    assign loop_en = loop_reg[stc_pkg::LOOP_EN_BIT];
    assign prediv = loop_reg[stc_pkg::LOOP_PREDIV_LSB +: 3];
    assign mult = loop_reg[stc_pkg::LOOP_MULT_LSB +: 5];
    // Loop needs its reference running as well
    assign loop_run = loop_en & osc_en; // R5 R18
    assign act_cfg = lp_mode_i ? vlp_reg : run_reg; // R12
    assign act_src = act_cfg[stc_pkg::SYSSRC_LSB +: 4];
    assign act_core = act_cfg[stc_pkg::COREDIV_LSB +: 4];
    assign act_bus = act_cfg[stc_pkg::BUSDIV_LSB +: 4];
    assign psel = peri_reg[stc_pkg::PSEL_LSB +: 3];
    assign high_range_o = (osc_range == stc_pkg::RANGE_HIGH); // R1
    assign stat_word = {24'h00_0000, high_range_o, act_src,
        lp_mode_i, loop_run, osc_en};

    // ------------------------------------------------------------
    // Crystal oscillator and loop
    // ------------------------------------------------------------
    logic crystal_input_s1, crystal_input_s2, pin_s1, pin_s2, ref_last;
    logic ref_now, osc_tick, next_osc_tick;
    logic [7:0] credit;
    logic [8:0] next_credit, sum;
    logic [4:0] den;
    logic emit, loop_tick, next_loop_tick;

    // Pin inputs are asynchronous: two flops before any use
    assign ref_now = ref_sel ? crystal_input_s2 : pin_s2; // R3
    assign den = {1'b0, prediv, 1'b0} + 5'h02;
    assign emit = loop_run && ({1'b0, credit} >= {4'h0, den});

    always_comb begin
        next_osc_tick = osc_en & ref_now & ~ref_last; // R2
        sum = {1'b0, credit};
        if (osc_tick) begin
            sum = sum + {3'h0, {1'b0, mult} + stc_pkg::LOOP_MULT_BASE}; // R4 R6
        end
        if (emit) begin
            sum = sum - {4'h0, den};
        end
        // Saturates: rates above clk_i cannot be shown as enables
        next_credit = (sum > stc_pkg::CREDIT_MAX) ? stc_pkg::CREDIT_MAX : sum;
        if (!loop_run) begin
            next_credit = 9'h000; // R5
        end
        next_loop_tick = emit; // R5
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crystal_input_s1 <= 1'b0;
            crystal_input_s2 <= 1'b0;
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            ref_last <= 1'b0;
            osc_tick <= 1'b0;
            credit <= 8'h00;
            loop_tick <= 1'b0;
        end else begin
            crystal_input_s1 <= crystal_input_i;
            crystal_input_s2 <= crystal_input_s1;
            pin_s1 <= external_clock_pin_i;
            pin_s2 <= pin_s1;
            ref_last <= ref_now;
            osc_tick <= next_osc_tick;
            credit <= next_credit[7:0];
            loop_tick <= next_loop_tick;
        end
    end

    // ------------------------------------------------------------
    // System, core and bus clocks
    // ------------------------------------------------------------
    logic fast_g, slow_g, sys_tick, sys_on, core_tick, bus_tick;

    assign fast_g = fast_en & fast_rc_tick_i; // R14
    assign slow_g = slow_en & slow_rc_tick_i; // R14
    assign sys_tick = pick_src(act_src, osc_tick, slow_g, fast_g, loop_tick);
    assign sys_on = pick_src(act_src, osc_en, slow_en, fast_en, loop_run);

    stc_tick_div u_core_div ( // R10
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_on_i(sys_on),
        .tick_i(sys_tick),
        .ratio_i(act_core),
        .tick_o(core_tick)
    );

    stc_tick_div u_bus_div ( // R11
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_on_i(sys_on),
        .tick_i(core_tick),
        .ratio_i(act_bus),
        .tick_o(bus_tick)
    );

    // ------------------------------------------------------------
    // Second-stage dividers and peripheral clocks
    // ------------------------------------------------------------
    logic [3:0] divb_in, divb_on, divb_tick;
    logic next_pbus, next_pfunc, pbus, pfunc, lpo_q;

    assign divb_in = {loop_tick, fast_g, slow_g, osc_tick};
    assign divb_on = {loop_run, fast_en, slow_en, osc_en};

    for (genvar g = 0; g < 4; g++) begin : g_divb
        stc_tick_div u_divb (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .src_on_i(divb_on[g]),
            .tick_i(divb_in[g]),
            .ratio_i(peri_reg[g*4 +: 4]),
            .tick_o(divb_tick[g])
        );
    end

    always_comb begin
        next_pbus = bus_tick & peri_reg[stc_pkg::PBUS_EN_BIT]; // R15
        next_pfunc = pick_src({1'b0, psel}, divb_tick[0], divb_tick[1],
            divb_tick[2], divb_tick[3]); // R15 R16
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pbus <= 1'b0;
            pfunc <= 1'b0;
            lpo_q <= 1'b0;
        end else begin
            pbus <= next_pbus;
            pfunc <= next_pfunc;
            lpo_q <= low_power_osc_tick_i;
        end
    end

    assign crystal_osc_clock_o = osc_tick;
    assign loop_clock_o = loop_tick;
    assign platform_clock_o = core_tick;
    assign bus_clock_o = bus_tick;
    assign periph_bus_clock_o = pbus;
    assign periph_func_clock_o = pfunc;
    assign low_power_osc_clock_o = lpo_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_range_high: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        $rose(osc_range == 2'h3) |-> high_range_o)
        else $error("range 3 did not select high range");
    a_osc_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        !osc_en |=> !crystal_osc_clock_o)
        else $error("oscillator ticked while disabled");
    a_ref_pick: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        osc_en && ref_sel && $stable(ref_sel) && crystal_input_s2 && !ref_last
        |=> crystal_osc_clock_o)
        else $error("crystal edge did not make an oscillator tick");
    a_loop_off: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        !loop_en |=> !loop_clock_o ##1 !loop_clock_o)
        else $error("loop ticked while disabled");
    a_loop_ref: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        credit == 8'h00 && !osc_tick |=> !loop_clock_o)
        else $error("loop ticked without oscillator reference");
    a_loop_ratio: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        osc_tick && credit == 8'h00 && loop_run && prediv == 3'h0
        && mult == 5'h08 ##1 loop_run[*8] |=> $past(credit, 8) == 8'h18
        && loop_clock_o && $past(loop_clock_o, 2) && $past(loop_clock_o, 4)
        && $past(loop_clock_o, 7))
        else $error("loop ratio 24/2 not met");
    a_sys_loop: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        act_src == 4'h6 |-> sys_tick == loop_tick && sys_on == loop_run)
        else $error("source 6 did not route the loop");
    a_sys_slow: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        act_src == 4'h2 && slow_en |-> sys_tick == slow_rc_tick_i)
        else $error("source 2 did not route the slow RC");
    a_core_half: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        core_tick && sys_on && act_core == 4'h1 && $stable(act_core)
        |-> !$past(core_tick))
        else $error("core divide by two broken");
    a_bus_feed: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        bus_clock_o |-> $past(core_tick))
        else $error("bus tick without core tick");
    a_mode_set: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        lp_mode_i |-> act_core == vlp_reg[19:16] && act_bus == vlp_reg[3:0])
        else $error("low power set not used");
    a_pbus_follow: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        periph_bus_clock_o |-> $past(bus_tick))
        else $error("peripheral bus clock not from bus clock");
    a_pfunc_stop: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        psel == 3'h0 |=> !periph_func_clock_o)
        else $error("function clock ran with select 0");

endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the system clock tree control block
`timescale 1ns/1ps
module testbench;
    // ----------------------------------------------------------------
    // Signals and counters
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic crystal_input_i = 1'b0;
    logic external_clock_pin_i = 1'b0;
    logic fast_rc_tick_i = 1'b0;
    logic slow_rc_tick_i = 1'b0;
    logic low_power_osc_tick_i = 1'b0;
    logic lp_mode_i = 1'b0;
    logic [6:0] outs;
    int tcnt = 0;
    int cnt[7];
    int num_errors = 0;
    int n_compared = 0;

    always #12.5 clk_i = ~clk_i;

    stc_clock_tree uut (
        .clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .crystal_input_i(crystal_input_i),
        .external_clock_pin_i(external_clock_pin_i),
        .fast_rc_tick_i(fast_rc_tick_i), .slow_rc_tick_i(slow_rc_tick_i),
        .low_power_osc_tick_i(low_power_osc_tick_i), .lp_mode_i(lp_mode_i),
        .crystal_osc_clock_o(outs[0]), .loop_clock_o(outs[1]),
        .platform_clock_o(outs[2]), .bus_clock_o(outs[3]),
        .periph_bus_clock_o(outs[4]), .periph_func_clock_o(outs[5]),
        .low_power_osc_clock_o(outs[6]), .high_range_o());

    // ----------------------------------------------------------------
    // Root sources: periods 16 crystal, 10 pin, 2 fast, 4 slow, 8 lp
    // ----------------------------------------------------------------
    always @(posedge clk_i) begin
        tcnt <= tcnt + 1;
        crystal_input_i <= tcnt[3];
        external_clock_pin_i <= (tcnt % 10) < 5;
        fast_rc_tick_i <= (tcnt % 2) == 0;
        slow_rc_tick_i <= (tcnt % 4) == 0;
        low_power_osc_tick_i <= (tcnt % 8) == 0;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        if (num_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        // Waitrequest and read data are judged at the rising edge itself
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) check("bus answer", 32'h1, 32'h0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check("register", q, exp);
    endtask

    // Window of 800 cycles is a whole number of every pattern period
    task automatic measure();
        repeat (64) @(posedge clk_i);
        for (int i = 0; i < 7; i++) cnt[i] = 0;
        repeat (800) begin
            @(negedge clk_i);
            for (int i = 0; i < 7; i++) cnt[i] += (outs[i] === 1'b1);
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd(stc_pkg::OFS_OSC, 32'h0000_0030);
        rd(stc_pkg::OFS_LOOP, 32'h0);
        rd(stc_pkg::OFS_RUN, 32'h0200_0000);
        rd(stc_pkg::OFS_VLP, 32'h0200_0000);
        rd(stc_pkg::OFS_PERI, 32'h0);
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18, 32'h0);
        avs_byteenable_i <= 4'h2;
        wr(stc_pkg::OFS_PERI, 32'hffff_ffff);
        avs_byteenable_i <= 4'hf;
        rd(stc_pkg::OFS_PERI, 32'h0000_ff00);
        wr(stc_pkg::OFS_PERI, 32'h0);
    endtask

    task automatic t_default();
        measure();
        check("crystal clk", cnt[0], 0);
        check("loop clk", cnt[1], 0);
        check("platform clk", cnt[2], 200);
        check("bus clk", cnt[3], 200);
        check("func clk", cnt[5], 0);
        check("lp osc clk", cnt[6], 100);
    endtask

    task automatic t_osc();
        wr(stc_pkg::OFS_OSC, 32'h3f);
        // New range only shows after the write edge has passed
        @(negedge clk_i);
        check("high range", uut.high_range_o, 1);
        measure();
        check("crystal clk", cnt[0], 50);
        wr(stc_pkg::OFS_OSC, 32'h37);
        measure();
        check("pin clk", cnt[0], 80);
    endtask

    task automatic t_loop();
        wr(stc_pkg::OFS_OSC, 32'h3f);
        wr(stc_pkg::OFS_LOOP, 32'h81);
        wr(stc_pkg::OFS_RUN, 32'h0601_0001);
        rd(stc_pkg::OFS_STAT, 32'h0000_00b3);
        measure();
        check("loop clk", cnt[1], 600);
        check("platform clk", cnt[2], 300);
        check("bus clk", cnt[3], 150);
    endtask

    task automatic t_gate();
        wr(stc_pkg::OFS_LOOP, 32'h80);
        measure();
        check("loop off", cnt[1], 0);
        check("platform off", cnt[2], 0);
        wr(stc_pkg::OFS_LOOP, 32'h81);
        wr(stc_pkg::OFS_OSC, 32'h3e);
        measure();
        check("crystal off", cnt[0], 0);
        check("loop no ref", cnt[1], 0);
        wr(stc_pkg::OFS_OSC, 32'h3f);
        measure();
        check("loop resumed", cnt[1], 600);
    endtask

    task automatic t_div();
        wr(stc_pkg::OFS_RUN, 32'h030f_0000);
        measure();
        check("core div 16", cnt[2], 25);
        @(posedge clk_i);
        lp_mode_i <= 1'b1;
        measure();
        check("lp mode set", cnt[2], 200);
        @(posedge clk_i);
        lp_mode_i <= 1'b0;
    endtask

    task automatic t_periph();
        logic [3:0] sel[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6};
        int exp[5] = '{0, 50, 50, 200, 100};
        wr(stc_pkg::OFS_RUN, 32'h0300_0000);
        for (int i = 0; i < 5; i++) begin
            wr(stc_pkg::OFS_PERI, 32'h0010_5130 | {12'h0, sel[i], 16'h0});
            measure();
            check("func clk", cnt[5], exp[i]);
            check("periph bus clk", cnt[4], 400);
        end
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_default();
        t_osc();
        t_loop();
        t_gate();
        t_div();
        t_periph();
        final_report();
    end

    initial begin
        repeat (30000) @(posedge clk_i);
        num_errors++;
        final_report();
    end
endmodule
